// [hdl/dxr_fifo.sv]
`timescale 1ns/1ps
module dxr_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
)
(
  input  wire logic   clk_sys_i,
  input  wire logic   resetn_i,
  dxr_stream_if.snk   in_if,
  dxr_stream_if.src   out_if
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          rdy_reg;
  logic          rdy_next;
  logic          vld_reg;
  logic          vld_next;
  logic          push;
  logic          pop;
  logic [W-1:0]  rd_data_reg;

  assign push         = in_if.valid && rdy_reg;
  assign pop          = vld_reg && out_if.ready;
  assign in_if.ready  = rdy_reg;
  assign out_if.valid = vld_reg;
  assign out_if.data  = rd_data_reg;

  always_comb
  begin
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    else if (pop && !push)
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    rdy_next = cnt_next != (AW+1)'(DEPTH);
    vld_next = cnt_next != '0;
  end

  // Read data leave a register; a write into the next read slot is bypassed
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem[wr_reg] <= in_if.data;
    if (push && wr_reg == rd_next)
      rd_data_reg <= in_if.data;
    else
      rd_data_reg <= mem[rd_next];
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
      vld_reg <= 1'b0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
      vld_reg <= vld_next;
    end
  end

  AST_FIFO_FULL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cnt_reg == (AW+1)'(DEPTH) |-> !rdy_reg && vld_reg)
    else $error("fifo full but still ready");
  AST_FIFO_COUNT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    push && !pop |=> cnt_reg == (AW+1)'($past(cnt_reg) + 1'b1))
    else $error("fifo count did not grow on push");
endmodule

// [hdl/dxr_pkg.sv]
package dxr_pkg;
  localparam int       ACC_W        = 12;
  localparam int       TMP_W        = 10;
  localparam int       CFG_W        = 8;
  localparam int       CFG_AXIS_BIT = 3;
  localparam int       CFG_PM_BIT   = 0;
  localparam logic [7:0]  CFG_RESET = 8'h04;
  localparam logic [11:0] ACC_MID   = 12'h0800;
  localparam logic [11:0] ACC_MAX   = 12'h0FFF;
  localparam logic [13:0] SELF_DELTA = 14'h00CD;
  // Counter values are edge numbers minus one
  localparam logic [3:0] SAMPLE_IDX = 4'h1;
  localparam logic [3:0] CFG_LAST   = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam logic [3:0] TMP_BITS   = 4'hA;
  localparam int       TMP_PAD      = 6;
  localparam int       CLK_MHZ      = 25;
  localparam int       TCONV_US     = 350;
  localparam int       TCONV_CYC    = TCONV_US * CLK_MHZ;
  localparam int       TFIFO_DEPTH  = 8;
  localparam int       PIN_W        = 5;
  // Selects idle high, clock/data/selfcheck low
  localparam logic [4:0] PIN_RST    = 5'h06;
  localparam logic [2:0] EDGE_RST   = 3'h6;

  typedef enum logic [1:0] {
    DXR_IDLE  = 2'b00,
    DXR_ACCEL = 2'b01,
    DXR_TEMP  = 2'b10
  } dxr_state_e;
endpackage

// [hdl/dxr_readout.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Acceleration sample is 12-bit offset binary, 0x800 meaning zero g.
// RULE_02 - One LSB is 1/256 g about midscale: +5 g is 0xD00, -5 g is 0x300.
// RULE_03 - Selfcheck input high shifts the reported code by 205 LSB.
// RULE_04 - Host never asserts both selects together.
// RULE_05 - Accel select falling starts frame; sample taken on second rising clock edge.
// RULE_06 - Serial clock is the conversion clock; a conversion takes 16 clocks.
// RULE_07 - Accel select rising releases serial output to high impedance.
// RULE_08 - Select still low after 16 clocks starts the next frame at once.
// RULE_09 - Host writes control bits 6,5,4,1 low and bit 2 high.
// RULE_10 - Control bit 3 picks the axis: 0 x-axis, 1 y-axis.
// RULE_11 - Control bit 0 picks mode: 0 normal, 1 shutdown.
// RULE_12 - Control register keeps its contents during shutdown.
// RULE_13 - Mode changes on update; wake from shutdown on 16th rising edge.
// RULE_14 - Control data is captured from serial input on rising clock edges.
// RULE_15 - Host samples the accelerometer at no more than 10 kSPS.
// RULE_16 - Temperature frame gives a leading zero then 10 data bits.
// RULE_17 - Temperature transfers run in frames of 16 clock pulses.
// RULE_18 - Last temperature bit holds until temp select rises, then release.
// RULE_19 - Host keeps serial input low during temperature frames.
// RULE_20 - Host may take only the first eight bits of a temperature frame.
// RULE_21 - Output bits change on falling serial clock edges.
// RULE_22 - Temperature is 10-bit twos complement, quarter degree per LSB.
// RULE_23 - Temperature converts about every 350 us; reads give latest result.
// RULE_24 - Accel frame shifts leading zeros then the 12-bit sample, MSB first.
module dxr_readout
  import dxr_pkg::*;
#(
  parameter int TCONV_CYCLES = TCONV_CYC,
  parameter int FIFO_DEPTH   = TFIFO_DEPTH
)
(
  input  wire logic             clk_sys_i,
  input  wire logic             resetn_i,
  input  wire logic             sclk_i,
  input  wire logic             accel_select_n_i,
  input  wire logic             temp_select_n_i,
  input  wire logic             serial_in_i,
  input  wire logic             selfcheck_force_i,
  input  wire logic [ACC_W-1:0] accel_x_i,
  input  wire logic [ACC_W-1:0] accel_y_i,
  input  wire logic             temp_valid_i,
  input  wire logic [TMP_W-1:0] temp_data_i,
  output logic                  temp_ready_o,
  output logic                  temp_convert_o,
  output logic                  serial_out_o,
  output logic                  serial_out_oe_o,
  output logic                  accel_power_down_o,
  output logic                  axis_select_o
);
  localparam int TMR_W = $clog2(TCONV_CYCLES + 1);
  logic [PIN_W-1:0] pin_s;
  logic             sclk_s;
  logic             cs_n_s;
  logic             tcs_n_s;
  logic             din_s;
  logic             st_s;
  logic [2:0]       edge_q_reg;
  logic             rise;
  logic             fall;
  logic             cs_fall;
  logic             tcs_fall;
  dxr_stream_if #(.W(TMP_W)) in_if ();
  dxr_stream_if #(.W(TMP_W)) out_if ();
  dxr_sync #(
    .W   (PIN_W),
    .RST (PIN_RST)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   ({selfcheck_force_i, serial_in_i, temp_select_n_i,
                 accel_select_n_i, sclk_i}),
    .sync_o    (pin_s)
  );
  assign {st_s, din_s, tcs_n_s, cs_n_s, sclk_s} = pin_s;
  assign rise     = sclk_s && !edge_q_reg[0];
  assign fall     = !sclk_s && edge_q_reg[0];
  assign cs_fall  = edge_q_reg[1] && !cs_n_s;
  assign tcs_fall = edge_q_reg[2] && !tcs_n_s;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      edge_q_reg <= EDGE_RST;
    else
      edge_q_reg <= {tcs_n_s, cs_n_s, sclk_s};
  end
  // Sample code from the signed front-end value, 1/256 g per LSB
  logic [ACC_W-1:0] raw;
  logic [13:0]      sum;
  logic [ACC_W-1:0] sample_code;
  always_comb
  begin
    raw = axis_select_o ? accel_y_i : accel_x_i; // RULE_10
    sum = {{2{raw[ACC_W-1]}}, raw} + {2'h0, ACC_MID}; // RULE_01 RULE_02
    if (st_s)
      sum = sum + SELF_DELTA; // RULE_03
    // Clamp so selfcheck near full scale does not wrap to low codes
    sample_code = (sum > {2'h0, ACC_MAX}) ? ACC_MAX : sum[ACC_W-1:0];
  end
  // Temperature results queue here; the read port is locked out while a
  // temperature frame is shifting so the value cannot change mid-frame
  dxr_state_e       state_reg;
  dxr_state_e       state_next;
  logic [TMP_W-1:0] temp_reg;
  logic [TMP_W-1:0] temp_next;
  assign in_if.valid  = temp_valid_i;
  assign in_if.data   = temp_data_i;
  assign out_if.ready = state_reg != DXR_TEMP;
  dxr_fifo #(
    .W     (TMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .in_if     (in_if),
    .out_if    (out_if)
  );
  always_comb
  begin
    temp_next = temp_reg;
    if (out_if.valid && out_if.ready)
      temp_next = out_if.data; // RULE_23
  end
  // Serial frame engine
  logic [3:0]       cnt_reg;
  logic [3:0]       cnt_next;
  logic [15:0]      sh_reg;
  logic [15:0]      sh_next;
  logic [CFG_W-1:0] csh_reg;
  logic [CFG_W-1:0] csh_next;
  logic [CFG_W-1:0] cfg_reg;
  logic [CFG_W-1:0] cfg_next;
  logic             dout_next;
  logic             oe_next;
  logic             pd_next;
  logic             wake_reg;
  logic             wake_next;
  logic             commit;
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    csh_next   = csh_reg;
    cfg_next   = cfg_reg;
    dout_next  = serial_out_o;
    oe_next    = serial_out_oe_o;
    pd_next    = accel_power_down_o;
    wake_next  = wake_reg;
    commit     = 1'b0;
    unique case (state_reg)
      DXR_IDLE:
      begin
        oe_next = 1'b0;
        // Accel select wins if both selects fall in the same cycle; otherwise the first select to fall wins
        if (cs_fall) // RULE_04
        begin
          state_next = DXR_ACCEL; // RULE_05
          cnt_next   = '0;
          sh_next    = '0;
          dout_next  = 1'b0; // RULE_24
          oe_next    = 1'b1;
        end
        else if (tcs_fall)
        begin
          state_next = DXR_TEMP;
          cnt_next   = '0;
          sh_next    = {temp_reg, {TMP_PAD{1'b0}}}; // RULE_22
          dout_next  = 1'b0; // RULE_16
          oe_next    = 1'b1;
        end
      end
      DXR_ACCEL:
      begin
        if (cs_n_s)
        begin
          state_next = DXR_IDLE;
          oe_next    = 1'b0; // RULE_07
        end
        else
        begin
          if (rise)
          begin
            csh_next = {csh_reg[CFG_W-2:0], din_s}; // RULE_14
            cnt_next = cnt_reg + 4'h1; // RULE_06 RULE_08
            if (cnt_reg == CFG_LAST)
            begin
              commit   = 1'b1;
              cfg_next = csh_next; // RULE_10
              if (csh_next[CFG_PM_BIT])
              begin
                pd_next   = 1'b1; // RULE_11 RULE_13
                wake_next = 1'b0;
              end
              else if (accel_power_down_o)
                wake_next = 1'b1;
            end
            if (cnt_reg == SAMPLE_IDX && !accel_power_down_o)
              sh_next = {2'h0, sample_code, 2'h0}; // RULE_05 RULE_24
            if (cnt_reg == FRAME_LAST && wake_reg)
            begin
              pd_next   = 1'b0; // RULE_13
              wake_next = 1'b0;
            end
          end
          if (fall)
          begin
            dout_next = sh_reg[15]; // RULE_21
            sh_next   = {sh_reg[14:0], 1'b0};
          end
        end
      end
      DXR_TEMP:
      begin
        if (tcs_n_s)
        begin
          state_next = DXR_IDLE;
          oe_next    = 1'b0; // RULE_18
        end
        else if (fall && cnt_reg != TMP_BITS)
        begin
          // Remaining clocks of the 16-clock frame leave the last bit standing
          dout_next = sh_reg[15]; // RULE_17 RULE_18
          sh_next   = {sh_reg[14:0], 1'b0};
          cnt_next  = cnt_reg + 4'h1;
        end
      end
      default:
      begin
        state_next = DXR_IDLE;
        oe_next    = 1'b0;
      end
    endcase
  end
  // Autoconversion timer, restarted when a temperature read ends
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic             conv_next;
  logic             rd_end;
  assign rd_end = state_reg == DXR_TEMP && tcs_n_s;
  always_comb
  begin
    tmr_next  = tmr_reg - 1'b1;
    conv_next = 1'b0;
    if (rd_end)
      tmr_next = TMR_W'(TCONV_CYCLES - 1);
    else if (tmr_reg == '0)
    begin
      tmr_next  = TMR_W'(TCONV_CYCLES - 1);
      conv_next = 1'b1; // RULE_23
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg          <= DXR_IDLE;
      cnt_reg            <= '0;
      sh_reg             <= '0;
      csh_reg            <= '0;
      cfg_reg            <= CFG_RESET;
      serial_out_o       <= 1'b0;
      serial_out_oe_o    <= 1'b0;
      accel_power_down_o <= 1'b0;
      axis_select_o      <= CFG_RESET[CFG_AXIS_BIT];
      wake_reg           <= 1'b0;
      temp_reg           <= '0;
      tmr_reg            <= TMR_W'(TCONV_CYCLES - 1);
      temp_convert_o     <= 1'b0;
      temp_ready_o       <= 1'b0;
    end
    else
    begin
      state_reg          <= state_next;
      cnt_reg            <= cnt_next;
      sh_reg             <= sh_next;
      csh_reg            <= csh_next;
      cfg_reg            <= cfg_next; // RULE_12
      serial_out_o       <= dout_next;
      serial_out_oe_o    <= oe_next;
      accel_power_down_o <= pd_next;
      axis_select_o      <= cfg_next[CFG_AXIS_BIT];
      wake_reg           <= wake_next;
      temp_reg           <= temp_next;
      tmr_reg            <= tmr_next;
      temp_convert_o     <= conv_next;
      temp_ready_o       <= in_if.ready;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence accel_start_s;
    state_reg == DXR_IDLE && cs_fall;
  endsequence
  sequence wake_edge_s;
    state_reg == DXR_ACCEL && !cs_n_s && rise && cnt_reg == FRAME_LAST && wake_reg;
  endsequence
  sequence accel_rise_s;
    state_reg == DXR_ACCEL && !cs_n_s && rise;
  endsequence
  AST_MIDSCALE: assert property (!st_s |-> sample_code == (raw ^ ACC_MID)) // RULE_01
    else $error("offset binary code wrong");
  AST_SCALE: assert property (!st_s && raw == 12'h0500 |-> sample_code == 12'h0D00) // RULE_02
    else $error("plus five g code wrong");
  AST_SELFCHECK: assert property (st_s && raw == 12'h0B00 |-> sample_code == 12'h03CD) // RULE_03
    else $error("selfcheck shift wrong");
  AST_START: assert property (accel_start_s |=> serial_out_oe_o && !serial_out_o) // RULE_24
    else $error("frame did not start with driven zero");
  AST_SAMPLE: assert property (accel_rise_s and cnt_reg == SAMPLE_IDX // RULE_05
    && !accel_power_down_o |=> sh_reg[13:2] == $past(sample_code))
    else $error("sample not taken on second rising edge");
  AST_RELEASE: assert property (state_reg == DXR_ACCEL && cs_n_s |=> !serial_out_oe_o) // RULE_07
    else $error("output not released on select rise");
  AST_WRAP: assert property (accel_rise_s and cnt_reg == FRAME_LAST // RULE_08
    |=> state_reg == DXR_ACCEL && cnt_reg == 4'h0)
    else $error("next frame did not begin");
  AST_CAPTURE: assert property (accel_rise_s |=> csh_reg[0] == $past(din_s)) // RULE_14
    else $error("control bit not captured");
  AST_SHUTDOWN: assert property (commit && cfg_next[CFG_PM_BIT] // RULE_11
    |=> accel_power_down_o ##1 accel_power_down_o)
    else $error("shutdown not entered");
  AST_KEEP: assert property (accel_power_down_o && !commit |=> $stable(cfg_reg)) // RULE_12
    else $error("control register changed in shutdown");
  AST_WAKE: assert property (wake_edge_s |=> !accel_power_down_o) // RULE_13
    else $error("no wake on sixteenth rising edge");
  AST_FALL: assert property (state_reg == DXR_ACCEL && !cs_n_s && fall // RULE_21
    |=> serial_out_o == $past(sh_reg[15]))
    else $error("output not shifted on falling edge");
  AST_THOLD: assert property (state_reg == DXR_TEMP && !tcs_n_s && cnt_reg == TMP_BITS // RULE_18
    |=> $stable(serial_out_o))
    else $error("last temperature bit not held");
  AST_CONV: assert property (tmr_reg == '0 && !rd_end // RULE_23
    |=> temp_convert_o ##1 !temp_convert_o)
    else $error("conversion request not pulsed");
endmodule

// [hdl/dxr_stream_if.sv]
`timescale 1ns/1ps
interface dxr_stream_if #(parameter int W = 10);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [hdl/dxr_sync.sv]
`timescale 1ns/1ps
module dxr_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
)
(
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= RST;
      sync_o   <= RST;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

// [verif/dxr_host_model.sv]
`timescale 1ns/1ps
module dxr_host_model (
  input  wire logic clk_sys_i,
  input  wire logic dout_i,
  output logic      sclk_o,
  output logic      accel_select_n_o,
  output logic      temp_select_n_o,
  output logic      serial_in_o
);
  // Serial clock idles low and stands still between frames
  initial
  begin
    sclk_o           = 1'b0;
    accel_select_n_o = 1'b1;
    temp_select_n_o  = 1'b1;
    serial_in_o      = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge clk_sys_i);
  endtask

  // Data is taken late in the high phase, long after the falling-edge update has landed
  task automatic xfer(input logic temp, input logic [7:0] word, input int nbits,
                      output logic [31:0] rx);
    int k;
    rx = 32'h0000_0000;
    @(posedge clk_sys_i);
    if (temp)
      temp_select_n_o <= 1'b0;
    else
      accel_select_n_o <= 1'b0;
    for (k = 0; k < nbits; k++)
    begin
      serial_in_o <= !temp && (k % 16 < 8) && word[3'(7 - k % 16)];
      half();
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rx = {rx[30:0], dout_i};
      @(posedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    half();
    accel_select_n_o <= 1'b1;
    temp_select_n_o  <= 1'b1;
    serial_in_o      <= 1'b0;
    half();
    // Keeps acceleration sampling at or below 10 kSPS: 2500 cycles of 40 ns is 100 us
    if (!temp)
      repeat (2500) @(posedge clk_sys_i);
  endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import dxr_pkg::*;
;
  localparam int TCONV = 200;
  localparam int DEPTH = 8;
  localparam int LIMIT = 60000;

  logic             clk_sys_i   = 1'b0;
  logic             resetn_i    = 1'b0;
  logic             sclk;
  logic             acc_sel_n;
  logic             tmp_sel_n;
  logic             sdi;
  logic             selfcheck   = 1'b0;
  logic [ACC_W-1:0] accel_x     = 12'h000;
  logic [ACC_W-1:0] accel_y     = 12'hB00;
  logic             tvalid      = 1'b0;
  logic [TMP_W-1:0] tdata       = 10'h000;
  logic             temp_ready;
  logic             temp_convert;
  logic             sdo;
  logic             sdo_oe;
  logic             pdown;
  logic             axis;
  wire logic        dout_w;
  logic [31:0]      rx;
  int               n_mismatch  = 0;
  int               comparisons = 0;
  int               cycles      = 0;
  int               n_conv      = 0;
  int               c0;

  // The host sees a floating line whenever the device lets go
  assign dout_w = sdo_oe ? sdo : 1'bz;

  always #20 clk_sys_i = ~clk_sys_i;

  dxr_readout #(.TCONV_CYCLES(TCONV), .FIFO_DEPTH(DEPTH)) dut_u (
    .clk_sys_i         (clk_sys_i),
    .resetn_i          (resetn_i),
    .sclk_i            (sclk),
    .accel_select_n_i  (acc_sel_n),
    .temp_select_n_i   (tmp_sel_n),
    .serial_in_i       (sdi),
    .selfcheck_force_i (selfcheck),
    .accel_x_i         (accel_x),
    .accel_y_i         (accel_y),
    .temp_valid_i      (tvalid),
    .temp_data_i       (tdata),
    .temp_ready_o      (temp_ready),
    .temp_convert_o    (temp_convert),
    .serial_out_o      (sdo),
    .serial_out_oe_o   (sdo_oe),
    .accel_power_down_o(pdown),
    .axis_select_o     (axis)
  );

  dxr_host_model host_u (
    .clk_sys_i       (clk_sys_i),
    .dout_i          (dout_w),
    .sclk_o          (sclk),
    .accel_select_n_o(acc_sel_n),
    .temp_select_n_o (tmp_sel_n),
    .serial_in_o     (sdi)
  );

  task automatic give_verdict();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] texp(input logic [TMP_W-1:0] t);
    return {16'h0000, 1'b0, t, {5{t[0]}}};
  endfunction

  task automatic acc(input logic [7:0] word, input logic [31:0] exp);
    host_u.xfer(1'b0, word, 16, rx);
    check(rx, exp);
    check(32'(sdo_oe), 32'h0000_0000);
  endtask

  task automatic tmp(input logic [TMP_W-1:0] t);
    host_u.xfer(1'b1, 8'h00, 16, rx);
    check(rx, texp(t));
    repeat (2) @(posedge clk_sys_i);
    check(32'(sdo_oe), 32'h0000_0000);
  endtask

  task automatic push(input logic [TMP_W-1:0] t);
    @(posedge clk_sys_i);
    tvalid <= 1'b1;
    tdata  <= t;
    @(posedge clk_sys_i);
    tvalid <= 1'b0;
  endtask

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (temp_convert === 1'b1)
      n_conv++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    check(32'({pdown, axis, sdo_oe}), 32'h0000_0000);
    // Control words keep bits 6..4 and 1 low and bit 2 high
    acc(8'h04, 32'h0000_0800);
    accel_x <= 12'h500;
    // Axis changes only after this frame's sample was taken
    acc(8'h0C, 32'h0000_0D00);
    check(32'(axis), 32'h0000_0001);
    acc(8'h0C, 32'h0000_0300);
    selfcheck <= 1'b1;
    acc(8'h84, 32'h0000_0300 + 32'h0000_00CD);
    selfcheck <= 1'b0;
    check(32'(axis), 32'h0000_0000);
    host_u.xfer(1'b0, 8'h04, 32, rx);
    check(rx, 32'h0D00_0D00);
    acc(8'h0D, 32'h0000_0D00);
    check(32'({pdown, axis}), 32'h0000_0003);
    acc(8'h0D, 32'h0000_0000);
    check(32'({pdown, axis}), 32'h0000_0003);
    acc(8'h0C, 32'h0000_0000);
    check(32'({pdown, axis}), 32'h0000_0001);
    acc(8'h0C, 32'h0000_0300);
    // A word cut short by the select must not reach the register
    host_u.xfer(1'b0, 8'h04, 6, rx);
    check(32'(axis), 32'h0000_0001);
    push(10'h064);
    repeat (5) @(posedge clk_sys_i);
    tmp(10'h064);
    push(10'h3FF);
    repeat (5) @(posedge clk_sys_i);
    tmp(10'h3FF);
    // The FIFO stalls during a frame, so it fills; the ninth word is refused
    fork
      host_u.xfer(1'b1, 8'h00, 16, rx);
      begin
        repeat (12) @(posedge clk_sys_i);
        for (int i = 1; i <= 9; i++)
          push(10'h100 + 10'(i));
        repeat (2) @(posedge clk_sys_i);
        check(32'(temp_ready), 32'h0000_0000);
      end
    join
    check(rx, texp(10'h3FF));
    repeat (20) @(posedge clk_sys_i);
    check(32'(temp_ready), 32'h0000_0001);
    tmp(10'h108);
    c0 = n_conv;
    repeat (400) @(posedge clk_sys_i);
    check(32'(n_conv - c0), 32'h0000_0002);
    give_verdict();
  end
endmodule
